// ---- src/mise_exec.sv ----
// execution unit for a subset of the 8-bit core's instructions
//
// How it works
// [RQ1] clear watchdog zeroes the watchdog counter and its prescaler
// [RQ2] clear watchdog sets timeout and powerdown flags to one, nothing else
// [RQ3] call via accumulator pushes current program counter plus one to stack top
// [RQ4] then loads pc low byte from accumulator, high seven bits from latch; two cycles
// [RQ5] complement inverts the file register, result to accumulator or file, updates zero flag
// [RQ6] clear register writes zero to the file register and sets zero flag
// [RQ7] decrement subtracts one, result to accumulator or file, updates zero flag
// [RQ8] clear accumulator zeroes accumulator and sets zero flag
// [RQ9] decrement skip stores result, no flags; zero result discards next, two cycles
// [RQ10] byte instructions take a seven-bit file address and one destination bit
`timescale 1ns/1ps
module mise_exec (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire mise_pkg::mise_op_t instr_op,
    input wire logic [mise_pkg::FILE_ADDR_W-1:0] file_addr,
    input wire logic dest_sel,
    input wire logic [mise_pkg::DATA_W-1:0] file_rdata,
    input wire logic [mise_pkg::PC_W-1:0] pc_current,
    input wire logic [mise_pkg::PC_HIGH_W-1:0] pc_high_latch,
    input wire logic sleep_entry,
    output logic instr_ready,
    output logic [mise_pkg::DATA_W-1:0] accumulator,
    output logic zero_flag,
    output logic timeout_flag_n,
    output logic powerdown_flag_n,
    output logic file_wr_en,
    output logic [mise_pkg::FILE_ADDR_W-1:0] file_wr_addr,
    output logic [mise_pkg::DATA_W-1:0] file_wr_data,
    output logic stack_push,
    output logic [mise_pkg::PC_W-1:0] stack_top,
    output logic pc_load,
    output logic [mise_pkg::PC_W-1:0] pc_load_value,
    output logic skip_next,
    output logic [mise_pkg::WDT_COUNT_W-1:0] watchdog_counter
);
    import mise_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // decode

    mise_state_t state;
    mise_state_t next_state;
    logic accept;
    logic [DATA_W-1:0] alu_result;
    logic alu_zero;
    logic wdt_clear;
    logic wdt_timeout;
    logic is_clear_watchdog;
    logic is_call;
    logic is_decrement_skip;
    logic dec_clear_watchdog;
    logic dec_call;
    logic dec_uses_dest;
    logic dec_file_always;
    logic dec_acc_always;
    logic dec_sets_zero;
    logic dec_skip_on_zero;
    logic writes_result;
    logic to_file;
    logic to_accumulator;
    logic sets_zero_flag;
    logic takes_two_cycles;

    ////////////////////////////////////////////////////////////////////////////////
    // opcode table

    // unused codes decode to no effect, so a stray fetch changes nothing
    always_comb begin
        dec_clear_watchdog = 1'b0;
        dec_call = 1'b0;
        dec_uses_dest = 1'b0;
        dec_file_always = 1'b0;
        dec_acc_always = 1'b0;
        dec_sets_zero = 1'b0;
        dec_skip_on_zero = 1'b0;
        case (instr_op)
            no_operation_instr: begin
                dec_uses_dest = 1'b0;
            end
            clear_watchdog_instr: begin
                dec_clear_watchdog = 1'b1; // [RQ1] [RQ2]
            end
            call_via_accumulator_instr: begin
                dec_call = 1'b1; // [RQ3] [RQ4]
            end
            complement_register_instr: begin
                dec_uses_dest = 1'b1;
                dec_sets_zero = 1'b1; // [RQ5]
            end
            clear_register_instr: begin
                dec_file_always = 1'b1;
                dec_sets_zero = 1'b1; // [RQ6]
            end
            clear_accumulator_instr: begin
                dec_acc_always = 1'b1;
                dec_sets_zero = 1'b1; // [RQ8]
            end
            decrement_register_instr: begin
                dec_uses_dest = 1'b1;
                dec_sets_zero = 1'b1; // [RQ7]
            end
            decrement_skip_zero_instr: begin
                dec_uses_dest = 1'b1;
                dec_skip_on_zero = 1'b1; // [RQ9]
            end
            default: begin
                dec_uses_dest = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // controls qualified by acceptance

    assign accept = instr_valid && instr_ready && (state == st_execute);

    assign is_clear_watchdog = accept && dec_clear_watchdog;
    assign is_call = accept && dec_call;
    assign is_decrement_skip = accept && dec_skip_on_zero;

    // complement, decrement and decrement skip honour the destination selector
    assign writes_result = accept && dec_uses_dest;

    // clear register always targets the file, whatever the selector says
    assign to_file = (writes_result && (dest_sel == DEST_FILE))
        || (accept && dec_file_always); // [RQ10]
    assign to_accumulator = (writes_result && (dest_sel == DEST_ACCUMULATOR))
        || (accept && dec_acc_always);

    assign sets_zero_flag = accept && dec_sets_zero; // [RQ5] [RQ6] [RQ7] [RQ8]

    assign takes_two_cycles = is_call || (is_decrement_skip && alu_zero); // [RQ4] [RQ9]

    assign wdt_clear = is_clear_watchdog; // [RQ1]

    ////////////////////////////////////////////////////////////////////////////////
    // datapath helpers

    mise_alu u_alu (
        .op(instr_op),
        .operand(file_rdata),
        .result(alu_result),
        .result_zero(alu_zero)
    );

    mise_watchdog u_watchdog (
        .core_clk(core_clk),
        .reset(reset),
        .clear(wdt_clear),
        .watchdog_counter(watchdog_counter),
        .timeout_pulse(wdt_timeout)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // cycle sequencing

    always_comb begin
        next_state = state;
        case (state)
            st_execute: begin
                if (takes_two_cycles) begin
                    next_state = st_second_cycle; // [RQ4] [RQ9]
                end
            end
            st_second_cycle: begin
                next_state = st_execute;
            end
            default: begin
                next_state = st_execute;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= st_execute;
        end else begin
            state <= next_state;
        end
    end

    // ready drops for the filler cycle of a two-cycle instruction
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            instr_ready <= 1'b1;
        end else begin
            instr_ready <= (next_state == st_execute); // [RQ4] [RQ9]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // accumulator and file register write-back

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            accumulator <= DATA_ZERO;
        end else if (to_accumulator) begin
            accumulator <= alu_result; // [RQ5] [RQ7] [RQ8] [RQ9]
        end
    end

    // one write strobe per accepted instruction that targets the file
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            file_wr_en <= 1'b0;
        end else begin
            file_wr_en <= to_file;
        end
    end

    // address and data hold their last values between writes
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            file_wr_addr <= FILE_ADDR_ZERO;
            file_wr_data <= DATA_ZERO;
        end else if (to_file) begin
            file_wr_addr <= file_addr; // [RQ10]
            file_wr_data <= alu_result; // [RQ5] [RQ6] [RQ7] [RQ9]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status flags

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            zero_flag <= ZERO_FLAG_RESET;
        end else if (sets_zero_flag) begin
            zero_flag <= alu_zero; // [RQ5] [RQ6] [RQ7] [RQ8]
        end
    end

    // a timeout pulse in the same cycle as the clear still reports the timeout; a clear in the wrap cycle suppresses the pulse
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            timeout_flag_n <= TIMEOUT_FLAG_N_RESET;
        end else if (wdt_timeout) begin
            timeout_flag_n <= 1'b0;
        end else if (is_clear_watchdog) begin
            timeout_flag_n <= 1'b1; // [RQ2]
        end
    end

    // a sleep entry in the same cycle as the clear still reports the powerdown
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            powerdown_flag_n <= POWERDOWN_FLAG_N_RESET;
        end else if (sleep_entry) begin
            powerdown_flag_n <= 1'b0;
        end else if (is_clear_watchdog) begin
            powerdown_flag_n <= 1'b1; // [RQ2]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // return stack push and program counter load

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stack_push <= 1'b0;
        end else begin
            stack_push <= is_call; // [RQ3]
        end
    end

    // the return address wraps to zero past the top of program memory
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stack_top <= PC_ZERO;
        end else if (is_call) begin
            stack_top <= pc_current + PC_STEP; // [RQ3]
        end
    end

    // the new pc is issued together with the push, in the second cycle while ready is low
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pc_load <= 1'b0;
        end else begin
            pc_load <= is_call; // [RQ4]
        end
    end

    // the accumulator read here is its value from before this instruction
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pc_load_value <= PC_ZERO;
        end else if (is_call) begin
            pc_load_value <= {pc_high_latch, accumulator}; // [RQ4]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // skip of the following instruction

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            skip_next <= 1'b0;
        end else begin
            skip_next <= is_decrement_skip && alu_zero; // [RQ9]
        end
    end

endmodule

// ---- src/mise_pkg.sv ----
// constants, opcodes and state codes shared by the instruction execution block
package mise_pkg;

    localparam int DATA_W = 8;
    localparam int FILE_ADDR_W = 7;
    localparam int PC_W = 15;
    localparam int PC_LOW_W = 8;
    localparam int PC_HIGH_W = 7;
    localparam int WDT_PRESCALE_W = 8;
    localparam int WDT_COUNT_W = 8;

    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
    localparam logic [FILE_ADDR_W-1:0] FILE_ADDR_ZERO = 7'h00;
    localparam logic [FILE_ADDR_W-1:0] FILE_ADDR_MAX = 7'h7f;
    localparam logic [PC_W-1:0] PC_ZERO = 15'h0000;
    localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
    localparam logic [WDT_PRESCALE_W-1:0] WDT_PRESCALE_ZERO = 8'h00;
    localparam logic [WDT_PRESCALE_W-1:0] WDT_PRESCALE_STEP = 8'h01;
    localparam logic [WDT_PRESCALE_W-1:0] WDT_PRESCALE_LAST = 8'hff;
    localparam logic [WDT_COUNT_W-1:0] WDT_COUNT_ZERO = 8'h00;
    localparam logic [WDT_COUNT_W-1:0] WDT_COUNT_STEP = 8'h01;
    localparam logic [WDT_COUNT_W-1:0] WDT_COUNT_LAST = 8'hff;

    // destination selector values
    localparam logic DEST_ACCUMULATOR = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // status flag reset values (both inactive-low flags read one after reset)
    localparam logic TIMEOUT_FLAG_N_RESET = 1'b1;
    localparam logic POWERDOWN_FLAG_N_RESET = 1'b1;
    localparam logic ZERO_FLAG_RESET = 1'b0;

    typedef enum logic [2:0] {
        no_operation_instr = 3'b000,
        clear_watchdog_instr = 3'b001,
        call_via_accumulator_instr = 3'b010,
        complement_register_instr = 3'b011,
        clear_register_instr = 3'b100,
        clear_accumulator_instr = 3'b101,
        decrement_register_instr = 3'b110,
        decrement_skip_zero_instr = 3'b111
    } mise_op_t;

    typedef enum logic [0:0] {
        st_execute = 1'b0,
        st_second_cycle = 1'b1
    } mise_state_t;

endpackage

// ---- src/mise_alu.sv ----
// combinational result and zero detect for the byte-oriented operations
`timescale 1ns/1ps
module mise_alu (
    input wire mise_pkg::mise_op_t op,
    input wire logic [mise_pkg::DATA_W-1:0] operand,
    output logic [mise_pkg::DATA_W-1:0] result,
    output logic result_zero
);
    import mise_pkg::*;

    always_comb begin
        case (op)
            complement_register_instr: begin
                result = ~operand; // [RQ5]
            end
            clear_register_instr, clear_accumulator_instr: begin
                result = DATA_ZERO; // [RQ6] [RQ8]
            end
            decrement_register_instr, decrement_skip_zero_instr: begin
                result = operand - DATA_ONE; // [RQ7] [RQ9]
            end
            default: begin
                result = operand;
            end
        endcase
        result_zero = (result == DATA_ZERO);
    end

endmodule

// ---- src/mise_watchdog.sv ----
// watchdog prescaler and counter, both cleared together by the clear command
`timescale 1ns/1ps
module mise_watchdog (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clear,
    output logic [mise_pkg::WDT_COUNT_W-1:0] watchdog_counter,
    output logic timeout_pulse
);
    import mise_pkg::*;

    logic [WDT_PRESCALE_W-1:0] prescaler;
    logic prescale_tick;

    assign prescale_tick = (prescaler == WDT_PRESCALE_LAST);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prescaler <= WDT_PRESCALE_ZERO;
        end else if (clear) begin
            prescaler <= WDT_PRESCALE_ZERO; // [RQ1]
        end else begin
            prescaler <= prescaler + WDT_PRESCALE_STEP;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            watchdog_counter <= WDT_COUNT_ZERO;
        end else if (clear) begin
            watchdog_counter <= WDT_COUNT_ZERO; // [RQ1]
        end else if (prescale_tick) begin
            watchdog_counter <= watchdog_counter + WDT_COUNT_STEP;
        end
    end

    // one-cycle pulse when the counter wraps
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            timeout_pulse <= 1'b0;
        end else begin
            timeout_pulse <= !clear && prescale_tick && (watchdog_counter == WDT_COUNT_LAST);
        end
    end

endmodule

// ---- dv/mise_file_model.sv ----
// data register file model that serves the execution block
`timescale 1ns/1ps
module mise_file_model (
    input wire logic core_clk,
    input wire logic [6:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic wr_en,
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data
);
    // content starts equal to the address, so expectations are easy to reckon
    logic [7:0] mem [0:127];
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = i[7:0];
        end
    end
    assign rd_data = mem[rd_addr];
    always @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end
endmodule

// ---- dv/mise_exec_properties.sv ----
// concurrent checks on the execution block ports
`timescale 1ns/1ps
module mise_exec_properties (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire mise_pkg::mise_op_t instr_op,
    input wire logic [6:0] file_addr,
    input wire logic dest_sel,
    input wire logic [7:0] file_rdata,
    input wire logic [14:0] pc_current,
    input wire logic [6:0] pc_high_latch,
    input wire logic sleep_entry,
    input wire logic instr_ready,
    input wire logic [7:0] accumulator,
    input wire logic zero_flag,
    input wire logic timeout_flag_n,
    input wire logic powerdown_flag_n,
    input wire logic file_wr_en,
    input wire logic [6:0] file_wr_addr,
    input wire logic [7:0] file_wr_data,
    input wire logic stack_push,
    input wire logic [14:0] stack_top,
    input wire logic pc_load,
    input wire logic [14:0] pc_load_value,
    input wire logic skip_next,
    input wire logic [7:0] watchdog_counter
);
    import mise_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    logic tk;
    assign tk = instr_valid && instr_ready;
    property p_cw;
        tk && instr_op == clear_watchdog_instr && !sleep_entry |=> watchdog_counter == 8'h00
            && timeout_flag_n && powerdown_flag_n && $stable(zero_flag);
    endproperty
    a_cw: assert property (p_cw) else $error("watchdog clear wrong");
    property p_push;
        tk && instr_op == call_via_accumulator_instr |=> stack_push
            && stack_top == $past(pc_current) + 15'h0001;
    endproperty
    a_push: assert property (p_push) else $error("return push wrong");
    property p_load;
        tk && instr_op == call_via_accumulator_instr |=> pc_load && !instr_ready
            && pc_load_value == {$past(pc_high_latch), $past(accumulator)} ##1 instr_ready;
    endproperty
    a_load: assert property (p_load) else $error("call load wrong");
    property p_comp;
        tk && instr_op == complement_register_instr && !dest_sel |=>
            accumulator == ~$past(file_rdata) && zero_flag == (accumulator == 8'h00);
    endproperty
    a_comp: assert property (p_comp) else $error("complement wrong");
    property p_clear_register_instr;
        tk && instr_op == clear_register_instr |=> file_wr_en && file_wr_data == 8'h00
            && file_wr_addr == $past(file_addr) && zero_flag;
    endproperty
    a_clear_register_instr: assert property (p_clear_register_instr) else $error("clear register wrong");
    property p_dec;
        tk && instr_op == decrement_register_instr && dest_sel |=> file_wr_en
            && file_wr_data == $past(file_rdata) - 8'h01 && zero_flag == (file_wr_data == 8'h00);
    endproperty
    a_dec: assert property (p_dec) else $error("decrement wrong");
    property p_clear_accumulator_instr;
        tk && instr_op == clear_accumulator_instr |=> accumulator == 8'h00 && zero_flag;
    endproperty
    a_clear_accumulator_instr: assert property (p_clear_accumulator_instr) else $error("clear accumulator wrong");
    property p_dsz;
        tk && instr_op == decrement_skip_zero_instr |=> skip_next == !instr_ready
            && skip_next == ($past(file_rdata) == 8'h01) && $stable(zero_flag);
    endproperty
    a_dsz: assert property (p_dsz) else $error("decrement skip wrong");
    c_call: cover property (tk && instr_op == call_via_accumulator_instr);
    c_skip: cover property (skip_next);
    c_cw: cover property (tk && instr_op == clear_watchdog_instr);
endmodule
bind mise_exec mise_exec_properties mise_exec_properties_inst (.*);

// ---- dv/mcu_instr_subset_exec_tb.sv ----
// self-checking bench for the instruction execution block
`timescale 1ns/1ps
module mcu_instr_subset_exec_tb;
    import mise_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic instr_valid = 1'b0;
    mise_op_t instr_op = no_operation_instr;
    logic [6:0] file_addr = 7'h00;
    logic dest_sel = 1'b0;
    logic [14:0] pc_current = 15'h0000;
    logic [6:0] pc_high_latch = 7'h00;
    logic sleep_entry = 1'b0;
    logic [7:0] file_rdata, accumulator, file_wr_data, watchdog_counter;
    logic instr_ready, zero_flag, timeout_flag_n, powerdown_flag_n;
    logic file_wr_en, stack_push, pc_load, skip_next;
    logic [6:0] file_wr_addr;
    logic [14:0] stack_top, pc_load_value;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    mise_exec mise_exec_inst (.*);
    mise_file_model mise_file_model_inst (.core_clk(core_clk), .rd_addr(file_addr),
        .rd_data(file_rdata), .wr_en(file_wr_en), .wr_addr(file_wr_addr),
        .wr_data(file_wr_data));
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 70000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (num_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one instruction, checked half a cycle after its effects land
    task automatic run(input mise_op_t op, input logic [6:0] a, input logic d);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        file_addr <= a;
        dest_sel <= d;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        @(negedge core_clk);
    endtask
    task automatic t_comp();
        run(complement_register_instr, 7'h7f, 1'b0);
        chk(accumulator, 8'h80);
        chk(file_wr_en, 1'b0);
        run(complement_register_instr, 7'h00, 1'b1);
        chk({file_wr_en, file_wr_addr, file_wr_data}, {1'b1, 7'h00, 8'hff});
        chk(accumulator, 8'h80);
        run(complement_register_instr, 7'h00, 1'b0);
        chk({zero_flag, accumulator}, {1'b1, 8'h00});
    endtask
    task automatic t_clear_accumulator_instr();
        run(complement_register_instr, 7'h7f, 1'b0);
        run(clear_accumulator_instr, 7'h00, 1'b0);
        chk({zero_flag, accumulator}, {1'b1, 8'h00});
    endtask
    task automatic t_dec();
        run(decrement_register_instr, 7'h01, 1'b0);
        chk({zero_flag, accumulator}, {1'b1, 8'h00});
        run(decrement_register_instr, 7'h05, 1'b1);
        chk({file_wr_en, file_wr_addr, file_wr_data}, {1'b1, 7'h05, 8'h04});
        chk({zero_flag, accumulator}, {1'b0, 8'h00});
        run(decrement_register_instr, 7'h05, 1'b0);
        chk(accumulator, 8'h03);
    endtask
    task automatic t_clear_register_instr();
        run(clear_register_instr, 7'h03, 1'b0);
        chk({file_wr_en, file_wr_addr, file_wr_data}, {1'b1, 7'h03, 8'h00});
        chk({zero_flag, accumulator}, {1'b1, 8'h03});
    endtask
    task automatic t_dsz();
        run(decrement_register_instr, 7'h09, 1'b0);
        run(decrement_skip_zero_instr, 7'h02, 1'b1);
        chk({skip_next, instr_ready, file_wr_data}, {2'b01, 8'h01});
        run(decrement_skip_zero_instr, 7'h02, 1'b0);
        chk({skip_next, instr_ready, accumulator}, {2'b10, 8'h00});
        chk(zero_flag, 1'b0);
        @(negedge core_clk);
        chk({skip_next, instr_ready}, 2'b01);
    endtask
    task automatic t_call();
        run(complement_register_instr, 7'h55, 1'b0);
        @(posedge core_clk);
        pc_current <= 15'h7ffe;
        pc_high_latch <= 7'h5a;
        run(call_via_accumulator_instr, 7'h00, 1'b0);
        chk({stack_push, stack_top}, {1'b1, 15'h7fff});
        chk({pc_load, instr_ready}, 2'b10);
        chk(pc_load_value, {7'h5a, 8'haa});
        @(negedge core_clk);
        chk({pc_load, stack_push, instr_ready}, 3'b001);
    endtask
    task automatic t_wdt();
        logic zb;
        @(posedge core_clk);
        sleep_entry <= 1'b1;
        @(posedge core_clk);
        sleep_entry <= 1'b0;
        repeat (600) @(posedge core_clk);
        @(negedge core_clk);
        chk(powerdown_flag_n, 1'b0);
        chk(watchdog_counter == 8'h00, 1'b0);
        zb = zero_flag;
        run(clear_watchdog_instr, 7'h00, 1'b0);
        chk(watchdog_counter, 8'h00);
        chk({timeout_flag_n, powerdown_flag_n, zero_flag}, {2'b11, zb});
        // a full watchdog period of idle cycles lets the counter wrap
        repeat (65600) @(posedge core_clk);
        @(negedge core_clk);
        chk(timeout_flag_n, 1'b0);
        run(clear_watchdog_instr, 7'h00, 1'b0);
        chk({timeout_flag_n, powerdown_flag_n, watchdog_counter}, {2'b11, 8'h00});
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        chk({instr_ready, timeout_flag_n, powerdown_flag_n, zero_flag}, 4'b1110);
        t_comp();
        t_clear_accumulator_instr();
        t_dec();
        t_clear_register_instr();
        t_dsz();
        t_call();
        t_wdt();
        end_sim();
    end
endmodule
